// *** hw/reset_ctrl_defines.vh ***
// Constants for the system reset control block.
`ifndef RESET_CTRL_DEFINES_VH
`define RESET_CTRL_DEFINES_VH
`define ADDR_CAUSE 4'h0
`define ADDR_BOR_CTRL 4'h1
`define ADDR_CORE_CTRL 4'h2
`define ADDR_SRC0 4'h3
`define ADDR_SRC1 4'h4
`define ADDR_SRC2 4'h5
`define ADDR_WD_LOAD 4'h6
`define ADDR_WD_CTRL 4'h7
`define ADDR_WD_CLEAR 4'h8
`define ADDR_WD_VALUE 4'h9
`define CAUSE_POR 0
`define CAUSE_PIN 1
`define CAUSE_BOR 2
`define CAUSE_SW 3
`define CAUSE_WD 4
`define BOR_RESET_EN_BIT 1
`define BOR_INTR_EN_BIT 0
`define SYSREQ_BIT 2
`define WD_EN_BIT 0
`define WD_RESEN_BIT 1
`define WD_LOAD_RST 32'hffffffff
`define REL_HOLD_NS 40
`define REL_HOLD_CYC ((`REL_HOLD_NS + 9) / 10)
`endif

// *** hw/system_reset_control.v ***
// System reset control: source collection, domain resets, cause flags and release sequencing.
// Notes on behaviour
// R1: Five reset sources are accepted.
// R2: Power-on resets core, peripherals and debug.
// R3: Pin reset spares debug TAP state.
// R4: Brown-out, software, watchdog spare debug.
// R5: Peripheral soft reset hits selected modules only.
// R6: Cause flag set, sticky across resets.
// R7: Power-on or pin clears other flags.
// R8: Hold reset until power-on detect ends.
// R9: Power-on indication only at first power-up.
// R10: Outside party holds pin reset long enough.
// R11: Brown-out reset disabled after reset.
// R12: Brown-out gives interrupt or reset.
// R13: Brown-out resets only when enable set.
// R14: Brown-out reset held while supply low.
// R15: Set-then-clear peripheral bit resets it.
// R16: Bit layout matches clock gating registers.
// R17: All clock domains of unit reset.
// R18: Core request bit resets whole system.
// R19: Watchdog interrupt first, reset second.
// R20: Counter reloads after first time-out.
// R21: Second zero resets if uncleared, enabled.
// R22: Test-mode pins tied low by board.
// R23: One cause flag per source, writable.
`timescale 1ns/1ps
`include "reset_ctrl_defines.vh"
module system_reset_control #(
    parameter PERIPH_W = 32,
    parameter DOMAINS = 2
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire pin_reset_n_in,
    input wire por_detect_in,
    input wire brownout_detect_in,
    input wire test_mode_pin_0_in,
    input wire test_mode_pin_1_in,
    input wire [3:0] addr_in,
    input wire [31:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [31:0] rdata_out,
    output reg core_rst_out,
    output reg debug_tap_rst_out,
    output reg debug_pin_cfg_rst_out,
    output reg [3*PERIPH_W*DOMAINS-1:0] periph_rst_out,
    output reg brownout_intr_out,
    output reg watchdog_intr_out,
    output reg fetch_start_out
);
    // States of the release sequencer, one-hot.
    localparam ST_HOLD = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam NP = 3 * PERIPH_W;
    localparam NR = NP * DOMAINS;
    // Delay count before release after the last source goes away.
    localparam [7:0] HOLD_LAST = `REL_HOLD_CYC - 1;

    // Sequencer, cause and control state.
    reg [1:0] state_r;
    reg [7:0] hold_cnt_r;
    reg por_seen_r;
    reg [4:0] reset_cause_reg_r;
    reg [1:0] power_brownout_ctrl_reg_r;
    reg [NP-1:0] periph_soft_reset_regs_r;
    reg [NP-1:0] soft_pulse_r;
    reg [31:0] watchdog_load_reg_r;
    reg [31:0] wd_cnt_r;
    reg [1:0] wd_ctrl_r;
    reg wd_intr_r;
    reg sys_req_r;
    reg wd_fire_r;
    reg [31:0] rdata_nxt;
    wire [NR-1:0] periph_rst_nxt;

    // Register strobe decode shared by all write paths except the peripheral word range.
    function wr_hit;
        input wr;
        input [3:0] a;
        input [3:0] t;
        begin
            wr_hit = wr && (a == t);
        end
    endfunction

    // One peripheral reset word out of the flat vector.
    function [31:0] pad;
        input [NP-1:0] v;
        input [1:0] idx;
        begin
            pad = v[idx*PERIPH_W +: PERIPH_W];
        end
    endfunction

    // Write decode; only the cause register is writable in hold.
    wire run = state_r == ST_RUN;
    wire wr_cause = wr_hit(wr_in, addr_in, `ADDR_CAUSE);
    wire wr_bor = run && wr_hit(wr_in, addr_in, `ADDR_BOR_CTRL);
    wire wr_core = run && wr_hit(wr_in, addr_in, `ADDR_CORE_CTRL);
    wire wr_load = run && wr_hit(wr_in, addr_in, `ADDR_WD_LOAD);
    wire wr_wdctl = run && wr_hit(wr_in, addr_in, `ADDR_WD_CTRL);
    wire wr_wdclr = run && wr_hit(wr_in, addr_in, `ADDR_WD_CLEAR);
    wire wr_src = run && wr_in && addr_in >= `ADDR_SRC0 && addr_in <= `ADDR_SRC2;
    // Offsets 3 to 5 select peripheral words 0 to 2.
    wire [1:0] src_idx = addr_in[1:0] - 2'd3;

    // Active reset sources.
    // R22: the test-mode pins are assumed tied low and are only read back.
    wire test_mode_any = test_mode_pin_0_in | test_mode_pin_1_in;
    wire por_act = por_detect_in && !por_seen_r; // R9
    wire pin_act = !pin_reset_n_in; // R3
    wire bor_act = brownout_detect_in && power_brownout_ctrl_reg_r[`BOR_RESET_EN_BIT]; // R13 R14
    wire any_src = por_act | pin_act | bor_act | sys_req_r | wd_fire_r; // R1
    wire hold_done = hold_cnt_r >= HOLD_LAST;
    wire release_now = !run && !any_src && hold_done; // R8
    wire wd_run = wd_ctrl_r[`WD_EN_BIT];

    // Cause bits raised by the sources that keep older flags.
    wire [4:0] cause_set = ({4'h0, bor_act} << `CAUSE_BOR)
        | ({4'h0, sys_req_r} << `CAUSE_SW)
        | ({4'h0, wd_fire_r} << `CAUSE_WD);
    wire [4:0] cause_clr = wr_cause ? wdata_in[4:0] : 5'h00;

    // Every clock domain of a unit sees the same reset pulse.
    genvar d;
    generate
        for (d = 0; d < DOMAINS; d = d + 1)
        begin : dom_copy
            assign periph_rst_nxt[d*NP +: NP] = soft_pulse_r; // R17
        end
    endgenerate

    // Hold and run sequencing.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            state_r <= ST_HOLD;
            hold_cnt_r <= 8'h00;
            por_seen_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_HOLD:
                begin
                    if (any_src)
                    begin
                        hold_cnt_r <= 8'h00;
                    end
                    else if (hold_done)
                    begin
                        state_r <= ST_RUN; // R8
                        por_seen_r <= 1'b1; // R9
                    end
                    else
                    begin
                        hold_cnt_r <= hold_cnt_r + 8'h01;
                    end
                end
                ST_RUN:
                begin
                    if (any_src)
                    begin
                        state_r <= ST_HOLD;
                        hold_cnt_r <= 8'h00;
                    end
                end
                default:
                begin
                    state_r <= ST_HOLD;
                    hold_cnt_r <= 8'h00;
                end
            endcase
        end
    end

    // Domain reset outputs, registered.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            core_rst_out <= 1'b1;
            debug_tap_rst_out <= 1'b1;
            debug_pin_cfg_rst_out <= 1'b1;
            periph_rst_out <= {NR{1'b1}};
            fetch_start_out <= 1'b0;
        end
        else
        begin
            fetch_start_out <= release_now; // R8 R18
            debug_tap_rst_out <= por_act; // R2 R3 R4
            debug_pin_cfg_rst_out <= por_act | pin_act; // R3
            if (run)
            begin
                core_rst_out <= 1'b0;
                periph_rst_out <= periph_rst_nxt; // R5 R17
            end
            else
            begin
                core_rst_out <= 1'b1; // R2 R4
                periph_rst_out <= {NR{1'b1}}; // R2 R4
            end
        end
    end

    // Cause flags: pin and power-on wipe the rest, other sets win over a clear.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            reset_cause_reg_r <= 5'h00;
        end
        else if (por_act)
        begin
            reset_cause_reg_r <= 5'h01 << `CAUSE_POR; // R7
        end
        else if (pin_act)
        begin
            reset_cause_reg_r <= 5'h01 << `CAUSE_PIN; // R7
        end
        else
        begin
            reset_cause_reg_r <= (reset_cause_reg_r & ~cause_clr) | cause_set; // R6 R23
        end
    end

    // Peripheral reset words: a set-then-clear gives a one-cycle pulse.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            periph_soft_reset_regs_r <= {NP{1'b0}};
            soft_pulse_r <= {NP{1'b0}};
        end
        else
        begin
            soft_pulse_r <= {NP{1'b0}};
            if (!run)
            begin
                periph_soft_reset_regs_r <= {NP{1'b0}};
            end
            else if (wr_src)
            begin
                periph_soft_reset_regs_r[src_idx * PERIPH_W +: PERIPH_W] <= wdata_in[PERIPH_W-1:0]; // R5
                soft_pulse_r[src_idx * PERIPH_W +: PERIPH_W] <=
                    pad(periph_soft_reset_regs_r, src_idx) & ~wdata_in[PERIPH_W-1:0]; // R15 R16
            end
        end
    end

    // Control registers, written only while running.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            power_brownout_ctrl_reg_r <= 2'h0;
            sys_req_r <= 1'b0;
            watchdog_load_reg_r <= `WD_LOAD_RST;
            wd_ctrl_r <= 2'h0;
        end
        else if (!run)
        begin
            sys_req_r <= 1'b0;
            wd_ctrl_r <= 2'h0;
            // Brown-out reset stays armed while it holds, and is disarmed at release.
            if (release_now)
            begin
                power_brownout_ctrl_reg_r <= 2'h0; // R11 R14
            end
        end
        else
        begin
            if (wr_bor)
            begin
                power_brownout_ctrl_reg_r <= wdata_in[1:0]; // R12 R13
            end
            if (wr_core && wdata_in[`SYSREQ_BIT])
            begin
                sys_req_r <= 1'b1; // R18
            end
            if (wr_load)
            begin
                watchdog_load_reg_r <= wdata_in; // R20
            end
            // Writes of the control word keep the enable bit once set.
            if (wr_wdctl)
            begin
                wd_ctrl_r <= wdata_in[1:0] | {1'b0, wd_ctrl_r[`WD_EN_BIT]};
            end
        end
    end

    // Watchdog: first zero raises the flag, second zero with flag and reset enable set fires.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            wd_cnt_r <= `WD_LOAD_RST;
            wd_intr_r <= 1'b0;
            wd_fire_r <= 1'b0;
        end
        else if (!run)
        begin
            wd_cnt_r <= watchdog_load_reg_r;
            wd_intr_r <= 1'b0;
            wd_fire_r <= 1'b0;
        end
        else if (wd_run)
        begin
            // A clear loses to a time-out in the same cycle.
            if (wd_cnt_r == 32'h00000000)
            begin
                wd_cnt_r <= watchdog_load_reg_r; // R20
                wd_intr_r <= 1'b1; // R19
                if (wd_intr_r && wd_ctrl_r[`WD_RESEN_BIT])
                begin
                    wd_fire_r <= 1'b1; // R21
                end
            end
            else if (wr_wdclr)
            begin
                wd_intr_r <= 1'b0;
                wd_cnt_r <= watchdog_load_reg_r;
            end
            else
            begin
                wd_cnt_r <= wd_cnt_r - 32'h00000001;
            end
        end
    end

    // Read mux for the register port.
    always @*
    begin
        rdata_nxt = 32'h00000000;
        case (addr_in)
            `ADDR_CAUSE: rdata_nxt = {27'h0000000, reset_cause_reg_r}; // R23
            `ADDR_BOR_CTRL: rdata_nxt = {30'h00000000, power_brownout_ctrl_reg_r};
            `ADDR_CORE_CTRL: rdata_nxt = {31'h00000000, test_mode_any};
            `ADDR_SRC0: rdata_nxt = pad(periph_soft_reset_regs_r, 2'd0);
            `ADDR_SRC1: rdata_nxt = pad(periph_soft_reset_regs_r, 2'd1);
            `ADDR_SRC2: rdata_nxt = pad(periph_soft_reset_regs_r, 2'd2);
            `ADDR_WD_LOAD: rdata_nxt = watchdog_load_reg_r;
            `ADDR_WD_CTRL: rdata_nxt = {29'h00000000, wd_intr_r, wd_ctrl_r};
            `ADDR_WD_VALUE: rdata_nxt = wd_cnt_r;
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    // Interrupt levels and read data, registered.
    always @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            rdata_out <= 32'h00000000;
            brownout_intr_out <= 1'b0;
            watchdog_intr_out <= 1'b0;
        end
        else
        begin
            watchdog_intr_out <= wd_intr_r; // R19
            brownout_intr_out <= brownout_detect_in && power_brownout_ctrl_reg_r[`BOR_INTR_EN_BIT]
                && !power_brownout_ctrl_reg_r[`BOR_RESET_EN_BIT]; // R12
            if (rd_in)
            begin
                rdata_out <= rdata_nxt;
            end
            else
            begin
                rdata_out <= 32'h00000000;
            end
        end
    end
endmodule

// *** verif/reset_board_model.sv ***
// Model of the board reset circuit and the supply detectors.
`timescale 1ns/1ps
module reset_board_model (
    input wire clk_in,
    input wire [2:0] req_in,
    output reg pin_n_out,
    output reg por_out,
    output reg bor_out,
    output wire tm_out
);
    assign tm_out = 1'b0;
    initial
    begin
        pin_n_out = 1'b1;
        por_out = 1'b1;
        bor_out = 1'b0;
    end
    always @(posedge clk_in)
    begin
        pin_n_out <= ~req_in[1];
        por_out <= req_in[0];
        bor_out <= req_in[2];
    end
endmodule

// *** verif/reset_ctrl_monitor.sv ***
// Checker on the reset control ports.
`timescale 1ns/1ps
module reset_ctrl_monitor #(
    parameter PERIPH_W = 32,
    parameter DOMAINS = 2
) (
    input wire clk_in,
    input wire sys_rst_in,
    input wire pin_reset_n_in,
    input wire por_detect_in,
    input wire core_rst_out,
    input wire debug_tap_rst_out,
    input wire debug_pin_cfg_rst_out,
    input wire [3*PERIPH_W*DOMAINS-1:0] periph_rst_out,
    input wire watchdog_intr_out,
    input wire fetch_start_out
);
    localparam W = 3 * PERIPH_W;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    fetch_core_a: assert property (fetch_start_out |=> !core_rst_out) else $error("core stuck");
    fetch_pulse_a: assert property (fetch_start_out |=> !fetch_start_out) else $error("long fetch");
    fetch_quiet_a: assert property (fetch_start_out |-> pin_reset_n_in && !por_detect_in) else $error("early go");
    pin_core_a: assert property (!pin_reset_n_in |-> ##[1:2] core_rst_out && debug_pin_cfg_rst_out) else $error("pin");
    tap_spare_a: assert property ((!por_detect_in) [*3] |=> !debug_tap_rst_out) else $error("tap hit");
    tap_por_a: assert property (por_detect_in |-> ##[1:2] debug_tap_rst_out) else $error("tap missed");
    hold_periph_a: assert property ($rose(core_rst_out) |-> ##[0:1] (&periph_rst_out)) else $error("periph");
    domain_copy_a: assert property (periph_rst_out[W-1:0] == periph_rst_out[2*W-1:W]) else $error("domain");
    cover property (fetch_start_out);
    cover property ($rose(watchdog_intr_out));
    cover property (!core_rst_out && |periph_rst_out);
endmodule

// *** verif/tb_top.sv ***
// Bench for the system reset control block.
`timescale 1ns/1ps
`include "reset_ctrl_defines.vh"
module tb_top;
    reg clk_in = 1'b0;
    reg sys_rst_in = 1'b1;
    reg [2:0] req = 3'h1;
    reg [3:0] addr = 4'h0;
    reg [31:0] wdata = 32'h0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [95:0] acc;
    wire pin_n, por, bor, tm, core, tap, pcfg, bintr, wintr, fetch;
    wire [31:0] rdata;
    wire [191:0] prst;
    wire [1:0] evt = {wintr, fetch};
    integer mismatches = 0;
    integer total_checks = 0;
    integer i;
    integer j;
    reset_board_model brd (.clk_in(clk_in), .req_in(req), .pin_n_out(pin_n), .por_out(por), .bor_out(bor), .tm_out(tm));
    system_reset_control dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_reset_n_in(pin_n),
        .por_detect_in(por), .brownout_detect_in(bor), .test_mode_pin_0_in(tm), .test_mode_pin_1_in(tm),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .core_rst_out(core),
        .debug_tap_rst_out(tap), .debug_pin_cfg_rst_out(pcfg), .periph_rst_out(prst),
        .brownout_intr_out(bintr), .watchdog_intr_out(wintr), .fetch_start_out(fetch));
    initial
        forever #5 clk_in = ~clk_in;
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("wrong value at %0t: %h vs %h", $time, got, exp);
        end
    end
    endtask
    task wr_reg(input [3:0] a, input [31:0] d);
    begin
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_in);
        wr <= 1'b0;
        @(posedge clk_in);
    end
    endtask
    task rd_chk(input [3:0] a, input [31:0] e);
    begin
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_in);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk_in);
    end
    endtask
    task wait_on(input integer k);
    begin
        #1 i = 0;
        while (evt[k] !== 1'b1 && i < 300)
        begin
            @(posedge clk_in);
            #1 i = i + 1;
        end
        chk(i < 300, 1);
        if (i >= 300)
            wrap_up;
        @(posedge clk_in);
    end
    endtask
    task src_pulse(input [2:0] r, input [31:0] cause);
    begin
        req <= r;
        repeat (12) @(posedge clk_in);
        #1 chk({core, tap, pcfg}, {2'h2, r == 3'h2});
        @(posedge clk_in);
        req <= 3'h0;
        wait_on(0);
        rd_chk(`ADDR_CAUSE, cause);
    end
    endtask
    task soft_rst(input [3:0] a, input integer n);
    begin
        wr_reg(a, 32'h1 << n);
        addr <= a;
        wdata <= 32'h0;
        wr <= 1'b1;
        acc = 96'h0;
        repeat (4)
        begin
            @(posedge clk_in);
            wr <= 1'b0;
            #1 acc = acc | prst[95:0];
        end
        chk(acc == (96'h1 << ((a - 4'h3) * 32 + n)), 1);
        chk(core, 0);
        @(posedge clk_in);
    end
    endtask
    initial
    begin
        repeat (8) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1 chk({core, tap}, 2'h3);
        @(posedge clk_in);
        req <= 3'h0;
        wait_on(0);
        rd_chk(`ADDR_CAUSE, 32'h1);
        src_pulse(3'h2, 32'h2);
        wr_reg(`ADDR_CORE_CTRL, 32'h1 << `SYSREQ_BIT);
        wait_on(0);
        rd_chk(`ADDR_CAUSE, 32'ha);
        req <= 3'h4;
        wr_reg(`ADDR_BOR_CTRL, 32'h1);
        repeat (2) @(posedge clk_in);
        #1 chk({core, bintr}, 2'h1);
        @(posedge clk_in);
        req <= 3'h0;
        repeat (3) @(posedge clk_in);
        wr_reg(`ADDR_BOR_CTRL, 32'h1 << `BOR_RESET_EN_BIT);
        src_pulse(3'h4, 32'he);
        req <= 3'h4;
        repeat (5) @(posedge clk_in);
        #1 chk(core, 0);
        @(posedge clk_in);
        req <= 3'h0;
        wr_reg(`ADDR_CAUSE, 32'h1f);
        rd_chk(`ADDR_CAUSE, 32'h0);
        rd_chk(4'hf, 32'h0);
        for (j = 3; j < 6; j = j + 1)
            soft_rst(j, j + 1);
        wr_reg(`ADDR_WD_LOAD, 32'h20);
        wr_reg(`ADDR_WD_CTRL, 32'h3);
        wr_reg(`ADDR_WD_CLEAR, 32'h0);
        wait_on(1);
        wait_on(0);
        rd_chk(`ADDR_CAUSE, 32'h10);
        wrap_up;
    end
endmodule
bind system_reset_control reset_ctrl_monitor #(.PERIPH_W(PERIPH_W), .DOMAINS(DOMAINS)) mon (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .pin_reset_n_in(pin_reset_n_in), .por_detect_in(por_detect_in),
    .core_rst_out(core_rst_out), .debug_tap_rst_out(debug_tap_rst_out), .debug_pin_cfg_rst_out(debug_pin_cfg_rst_out),
    .periph_rst_out(periph_rst_out), .watchdog_intr_out(watchdog_intr_out), .fetch_start_out(fetch_start_out));
